/* hw/thermal_pkg.sv */
// Package of constants and types for the die thermal monitor control block.
package thermal_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FLAG = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_SENSE = 8'h0c;
  localparam logic [7:0] ADDR_TEMP = 8'h10;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_AON_BIT = 1;
  localparam int SENSE_SHUTDOWN_BIT = 6;
  localparam int SENSE_MON_ON_BIT = 7;
  localparam int NUM_WARN = 6;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam logic [5:0] MASK_RESET = 6'h3f;

  // ==========================================================================
  // Thresholds in whole degrees Celsius, signed 9-bit
  // ==========================================================================
  localparam logic signed [8:0] WARN_T0 = 9'sd80;
  localparam logic signed [8:0] WARN_STEP = 9'sd15;
  localparam logic signed [8:0] WARN_HYS = 9'sd5;
  localparam logic signed [8:0] SHUTDOWN_T = 9'sd165;
  localparam logic signed [8:0] SHUTDOWN_HYS = 9'sd15;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLOCK_MHZ = 250;
  localparam int DEBOUNCE_US = 10;
  localparam int WINDOW_US = 450;
  localparam int INTERVAL_US = 3000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLOCK_MHZ;
  localparam int WINDOW_CYCLES = WINDOW_US * CLOCK_MHZ;
  localparam int INTERVAL_CYCLES = INTERVAL_US * CLOCK_MHZ;

  typedef enum logic [2:0] {
    MON_OFF = 3'b001,
    MON_ON = 3'b010,
    MON_SAMPLE = 3'b100
  } mon_state_type;

endpackage

/* hw/thermal_cmp_if.sv */
// Interface carrying the compare request and debounced results.
`timescale 1ns/1ps
interface thermal_cmp_if;
  logic sample_valid;
  logic signed [8:0] temp;
  logic [6:0] live;
  logic [6:0] rise;
  modport ctrl (output sample_valid, output temp, input live, input rise);
  modport cmp (input sample_valid, input temp, output live, output rise);
endinterface

/* hw/thermal_debounce.sv */
// Threshold comparators with hysteresis and bidirectional debounce.
`timescale 1ns/1ps
module thermal_debounce
  import thermal_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [31:0] i_debounce_cycles,
  thermal_cmp_if.cmp bus
);

  function automatic logic signed [8:0] level_of(input int idx);
    if (idx == NUM_WARN) begin
      return SHUTDOWN_T;
    end
    return WARN_T0 + 9'(idx) * WARN_STEP;
  endfunction

  function automatic logic signed [8:0] hys_of(input int idx);
    return (idx == NUM_WARN) ? SHUTDOWN_HYS : WARN_HYS;
  endfunction

  for (genvar g = 0; g < 7; g++) begin : gen_cmp
    logic [31:0] count;
    logic want;
    // At or above level asserts; only at or below level minus hysteresis releases.
    always_comb begin
      if (bus.live[g]) begin
        want = bus.temp > (level_of(g) - hys_of(g)); // RULE_04 RULE_05
      end else begin
        want = bus.temp >= level_of(g);
      end
    end

    always_ff @(posedge i_clock) begin
      if (i_rst) begin
        count <= 32'h0;
        bus.live[g] <= 1'b0;
        bus.rise[g] <= 1'b0;
      end else if (i_ce) begin
        bus.rise[g] <= 1'b0;
        if (!bus.sample_valid || want == bus.live[g]) begin
          count <= 32'h0;
        end else if (count + 32'h1 >= i_debounce_cycles) begin
          count <= 32'h0; // RULE_06
          bus.live[g] <= want;
          bus.rise[g] <= want;
        end else begin
          count <= count + 32'h1;
        end
      end
    end
  end

endmodule

/* hw/thermal_monitor.sv */
// Top level of the die thermal monitor control with AXI4-Lite registers.
`timescale 1ns/1ps
// Overview of operation
// RULE_01: Six warning thresholds 80..155 C, each with flag, live state, mask.
// RULE_02: Only the centre-of-die sensor feeds flags and shutdown.
// RULE_03: A rising warning crossing sets that threshold's interrupt flag.
// RULE_04: Live state releases only 5 C below its threshold.
// RULE_05: Above 165 C shut down; stay blocked until cooled by hysteresis.
// RULE_06: Every comparison is debounced 10 us in both directions.
// RULE_07: Enable bit 0 turns the monitor off, 1 turns it on.
// RULE_08: In run, always-on bit 1 keeps monitor on; 0 selects sampling.
// RULE_09: Sampling powers monitor 450 us out of every 3.0 ms.
// RULE_10: In standby only sampling is used, and only while enabled.
// RULE_11: A flag drives the low-active interrupt only when unmasked.
// RULE_12: Flags stay latched until cleared; live state tracks debounced compare.
module thermal_monitor
  import thermal_pkg::*;
#(
  parameter int DEBOUNCE_CNT = DEBOUNCE_CYCLES,
  parameter int WINDOW_CNT = WINDOW_CYCLES,
  parameter int INTERVAL_CNT = INTERVAL_CYCLES
)
(
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  input wire logic I_STANDBY,
  input wire logic signed [8:0] I_CENTER_TEMP,
  input wire logic I_CENTER_TEMP_VALID,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic O_MONITOR_ON,
  output logic O_SHUTDOWN,
  output logic O_IRQ_OUT_N
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  thermal_cmp_if cmp_bus ();
  logic temp_monitor_enable;
  logic temp_monitor_always_on;
  logic [5:0] threshold_irq_flag;
  logic [5:0] threshold_irq_mask;
  logic [5:0] threshold_live_state;
  logic shutdown_live;
  mon_state_type mon_state;
  logic [31:0] interval_count;
  logic have_aw;
  logic have_w;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic write_fire;
  logic [5:0] clear_bits;
  logic signed [8:0] sampled_temp;
  logic [31:0] next_rdata;
  logic next_rresp_err;

  function automatic logic is_mapped(input logic [7:0] addr);
    return addr == ADDR_CTRL || addr == ADDR_FLAG || addr == ADDR_MASK ||
           addr == ADDR_SENSE || addr == ADDR_TEMP;
  endfunction

  // ==========================================================================
  // Comparator and debounce
  // ==========================================================================
  // Only the centre sensor temperature enters the comparators.
  assign cmp_bus.temp = sampled_temp; // RULE_02
  assign cmp_bus.sample_valid = O_MONITOR_ON && I_CENTER_TEMP_VALID;
  assign threshold_live_state = cmp_bus.live[5:0]; // RULE_12
  assign shutdown_live = cmp_bus.live[6];

  thermal_debounce thermal_debounce_inst (
    .i_clock(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_ce(I_CE),
    .i_debounce_cycles(32'(DEBOUNCE_CNT)),
    .bus(cmp_bus.cmp)
  );

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      sampled_temp <= 9'sd0;
    end else if (I_CE && I_CENTER_TEMP_VALID) begin
      sampled_temp <= I_CENTER_TEMP;
    end
  end

  // ==========================================================================
  // Power state of the monitor
  // ==========================================================================
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      mon_state <= MON_OFF;
      interval_count <= 32'h0;
      O_MONITOR_ON <= 1'b0;
    end else if (I_CE) begin
      case (mon_state)
        MON_OFF: begin
          interval_count <= 32'h0;
          O_MONITOR_ON <= 1'b0;
          if (temp_monitor_enable) begin // RULE_07
            mon_state <= (temp_monitor_always_on && !I_STANDBY) ?
                         MON_ON : MON_SAMPLE;
            O_MONITOR_ON <= 1'b1;
          end
        end
        MON_ON: begin
          O_MONITOR_ON <= 1'b1;
          if (!temp_monitor_enable) begin
            mon_state <= MON_OFF; // RULE_07
            O_MONITOR_ON <= 1'b0;
          end else if (!temp_monitor_always_on || I_STANDBY) begin
            mon_state <= MON_SAMPLE; // RULE_08 RULE_10
            interval_count <= 32'h0;
          end
        end
        MON_SAMPLE: begin
          if (!temp_monitor_enable) begin
            mon_state <= MON_OFF; // RULE_10
            O_MONITOR_ON <= 1'b0;
          end else if (temp_monitor_always_on && !I_STANDBY) begin
            mon_state <= MON_ON; // RULE_08
            O_MONITOR_ON <= 1'b1;
          end else begin
            // On for the window at the start of each interval.
            if (interval_count + 32'h1 >= 32'(INTERVAL_CNT)) begin
              interval_count <= 32'h0; // RULE_09
              O_MONITOR_ON <= 1'b1;
            end else begin
              interval_count <= interval_count + 32'h1;
              O_MONITOR_ON <= (interval_count + 32'h1) < 32'(WINDOW_CNT);
            end
          end
        end
        default: begin
          mon_state <= MON_OFF;
          O_MONITOR_ON <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Shutdown
  // ==========================================================================
  // The shutdown comparator holds until it cools past its hysteresis.
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      O_SHUTDOWN <= 1'b0;
    end else if (I_CE) begin
      O_SHUTDOWN <= shutdown_live; // RULE_05
    end
  end

  // ==========================================================================
  // AXI4-Lite write
  // ==========================================================================
  assign write_fire = have_aw && have_w && !S_AXI_BVALID;

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
    end else if (I_CE) begin
      S_AXI_AWREADY <= !have_aw && !S_AXI_AWREADY && !S_AXI_BVALID;
      S_AXI_WREADY <= !have_w && !S_AXI_WREADY && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        have_aw <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        have_w <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (write_fire) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= is_mapped(aw_addr) ? 2'h0 : 2'h2;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      temp_monitor_enable <= CTRL_RESET[CTRL_EN_BIT];
      temp_monitor_always_on <= CTRL_RESET[CTRL_AON_BIT];
      threshold_irq_mask <= MASK_RESET;
    end else if (I_CE && write_fire && w_strb[0]) begin
      if (aw_addr == ADDR_CTRL) begin
        temp_monitor_enable <= w_data[CTRL_EN_BIT]; // RULE_07
        temp_monitor_always_on <= w_data[CTRL_AON_BIT];
      end
      if (aw_addr == ADDR_MASK) begin
        threshold_irq_mask <= w_data[5:0]; // RULE_01
      end
    end
  end

  // ==========================================================================
  // Interrupt flags
  // ==========================================================================
  assign clear_bits = (write_fire && w_strb[0] && aw_addr == ADDR_FLAG) ?
                      w_data[5:0] : 6'h0;

  // A new rising crossing wins over a clear in the same cycle.
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      threshold_irq_flag <= 6'h0;
    end else if (I_CE) begin
      threshold_irq_flag <= (threshold_irq_flag & ~clear_bits) |
                            cmp_bus.rise[5:0]; // RULE_03 RULE_12
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      O_IRQ_OUT_N <= 1'b1;
    end else if (I_CE) begin
      O_IRQ_OUT_N <= ~|(threshold_irq_flag & ~threshold_irq_mask); // RULE_11
    end
  end

  // ==========================================================================
  // AXI4-Lite read
  // ==========================================================================
  always_comb begin
    next_rdata = 32'h0;
    next_rresp_err = 1'b0;
    case (S_AXI_ARADDR)
      ADDR_CTRL: begin
        next_rdata[CTRL_EN_BIT] = temp_monitor_enable;
        next_rdata[CTRL_AON_BIT] = temp_monitor_always_on;
      end
      ADDR_FLAG: next_rdata[5:0] = threshold_irq_flag;
      ADDR_MASK: next_rdata[5:0] = threshold_irq_mask;
      ADDR_SENSE: begin
        next_rdata[5:0] = threshold_live_state;
        next_rdata[SENSE_SHUTDOWN_BIT] = O_SHUTDOWN;
        next_rdata[SENSE_MON_ON_BIT] = O_MONITOR_ON;
      end
      ADDR_TEMP: next_rdata[8:0] = sampled_temp;
      default: next_rresp_err = 1'b1;
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= 2'h0;
    end else if (I_CE) begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= next_rdata;
        S_AXI_RRESP <= next_rresp_err ? 2'h2 : 2'h0;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  irq_mask_gate_a: assert property ( // RULE_11
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_CE && |(threshold_irq_flag & ~threshold_irq_mask) |=> !O_IRQ_OUT_N)
    else $error("unmasked flag did not assert interrupt");
  irq_masked_off_a: assert property ( // RULE_11
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_CE && !(|(threshold_irq_flag & ~threshold_irq_mask)) |=> O_IRQ_OUT_N)
    else $error("interrupt asserted without unmasked flag");
  flag_set_a: assert property ( // RULE_03
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_CE && |cmp_bus.rise[5:0] |=>
    ((threshold_irq_flag & $past(cmp_bus.rise[5:0])) ==
     $past(cmp_bus.rise[5:0])))
    else $error("rising crossing did not set flag");
  flag_needs_live_a: assert property ( // RULE_03
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    1'b1 |=> ((threshold_irq_flag & ~$past(threshold_irq_flag) &
    ~$past(threshold_live_state)) == 6'h0))
    else $error("flag set without a live crossing");
  flag_latched_a: assert property ( // RULE_12
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    ##1 ($past(clear_bits) == 6'h0) |->
    ((threshold_irq_flag & $past(threshold_irq_flag)) ==
     $past(threshold_irq_flag)))
    else $error("flag dropped without clear");
  monitor_off_a: assert property ( // RULE_07
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_CE && !temp_monitor_enable ##1 I_CE && !temp_monitor_enable
    |=> !O_MONITOR_ON)
    else $error("monitor powered while disabled");
  always_on_a: assert property ( // RULE_08
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    (mon_state == MON_ON) |-> O_MONITOR_ON)
    else $error("always-on state with monitor off");
  standby_sample_a: assert property ( // RULE_10
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_CE && I_STANDBY && mon_state == MON_ON |=> mon_state != MON_ON)
    else $error("standby left monitor always on");
  sample_window_a: assert property ( // RULE_09
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    mon_state == MON_SAMPLE && interval_count >= 32'(WINDOW_CNT)
    |-> !O_MONITOR_ON)
    else $error("monitor on outside sampling window");
  sample_on_a: assert property ( // RULE_09
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    mon_state == MON_SAMPLE && interval_count < 32'(WINDOW_CNT)
    |-> O_MONITOR_ON)
    else $error("monitor off inside sampling window");
  shutdown_follow_a: assert property ( // RULE_05
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_CE |=> O_SHUTDOWN == $past(shutdown_live))
    else $error("shutdown does not follow comparator");
  shutdown_release_a: assert property ( // RULE_05
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
    !$past(I_SYS_RST) && $fell(shutdown_live) |->
    $past(sampled_temp) <= SHUTDOWN_T - SHUTDOWN_HYS)
    else $error("shutdown released above hysteresis point");

endmodule

/* dv/thermal_monitor_tb.sv */
// Self-checking testbench for the die thermal monitor control block.
`timescale 1ns/1ps
module thermal_monitor_tb;
  import thermal_pkg::*;
  localparam int DEB = 4;
  localparam int WIN = 10;
  localparam int INTV = 40;
  localparam int SETTLE = DEB + 6;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic standby = 1'b0;
  logic signed [8:0] temp = 9'h019;
  logic temp_valid = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic mon_on;
  logic shutdown;
  logic irq_n;
  logic [31:0] rd;
  int bad_count = 0;
  int tests_run = 0;

  always #2 clock = ~clock;

  thermal_monitor #(.DEBOUNCE_CNT(DEB), .WINDOW_CNT(WIN),
    .INTERVAL_CNT(INTV)) thermal_monitor_inst (
    .I_CLOCK(clock), .I_SYS_RST(rst), .I_CE(ce), .I_STANDBY(standby),
    .I_CENTER_TEMP(temp), .I_CENTER_TEMP_VALID(temp_valid),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .O_MONITOR_ON(mon_on),
    .O_SHUTDOWN(shutdown), .O_IRQ_OUT_N(irq_n));

  // ==========================================================================
  // Reporting
  // ==========================================================================
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    bad_count++;
    $display("[FAIL] t=%0t got %h expected %h", $time, 1'b0, 1'b1);
    give_verdict();
  endtask

  // ==========================================================================
  // AXI4-Lite master
  // ==========================================================================
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] exp_resp);
    int n;
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 60) hang();
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, exp_resp});
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          input logic [1:0] exp_resp);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 60) hang();
    d = rdata;
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, exp_resp});
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    axi_read(a, v, 2'h0);
    chk(v, exp);
  endtask

  task automatic set_temp(input logic signed [8:0] t, input int wait_n);
    @(posedge clock);
    temp <= t;
    repeat (wait_n) @(posedge clock);
    #1;
  endtask

  task automatic count_on(input int n, input int exp);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge clock);
      if (mon_on === 1'b1) c++;
    end
    chk(c, exp);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic test_reset();
    #1;
    chk({29'h0, mon_on, shutdown, irq_n}, 32'h5);
    chk_reg(ADDR_CTRL, {30'h0, CTRL_RESET});
    chk_reg(ADDR_MASK, {26'h0, MASK_RESET});
    chk_reg(ADDR_FLAG, 32'h0);
    axi_read(8'h20, rd, 2'h2);
    axi_write(8'h24, 32'hffff_ffff, 2'h2);
    wstrb <= 4'he;
    axi_write(ADDR_MASK, 32'h0, 2'h0);
    wstrb <= 4'hf;
    chk_reg(ADDR_MASK, {26'h0, MASK_RESET});
    $display("test_reset done");
  endtask

  task automatic test_levels();
    logic [5:0] exp;
    axi_write(ADDR_MASK, 32'h0, 2'h0);
    for (int i = 0; i < NUM_WARN; i++) begin
      exp = 6'((7'h1 << (i + 1)) - 7'h1);
      set_temp(WARN_T0 + 9'(i) * WARN_STEP, SETTLE);
      chk({31'h0, irq_n}, 32'h0);
      chk_reg(ADDR_SENSE, {24'h0, 2'h2, exp});
      chk_reg(ADDR_FLAG, {26'h0, exp});
    end
    set_temp(9'h0a5, SETTLE);
    chk({31'h0, shutdown}, 32'h1);
    chk_reg(ADDR_SENSE, 32'hff);
    chk_reg(ADDR_TEMP, 32'h0a5);
    set_temp(9'h097, SETTLE);
    chk({31'h0, shutdown}, 32'h1);
    set_temp(9'h095, SETTLE);
    chk({31'h0, shutdown}, 32'h0);
    chk_reg(ADDR_SENSE, 32'h9f);
    $display("test_levels done");
  endtask

  task automatic test_hysteresis();
    set_temp(9'h04c, SETTLE);
    chk_reg(ADDR_SENSE, 32'h81);
    set_temp(9'h04b, SETTLE);
    chk_reg(ADDR_SENSE, 32'h80);
    chk_reg(ADDR_FLAG, 32'h3f);
    chk({31'h0, irq_n}, 32'h0);
    axi_write(ADDR_FLAG, 32'h05, 2'h0);
    chk_reg(ADDR_FLAG, 32'h3a);
    axi_write(ADDR_FLAG, 32'h3a, 2'h0);
    chk_reg(ADDR_FLAG, 32'h0);
    repeat (3) @(posedge clock);
    #1;
    chk({31'h0, irq_n}, 32'h1);
    $display("test_hysteresis done");
  endtask

  task automatic test_debounce_mask();
    set_temp(9'h046, SETTLE);
    set_temp(9'h050, DEB - 2);
    set_temp(9'h046, SETTLE);
    chk_reg(ADDR_SENSE, 32'h80);
    chk_reg(ADDR_FLAG, 32'h0);
    axi_write(ADDR_MASK, 32'h01, 2'h0);
    set_temp(9'h050, SETTLE);
    chk_reg(ADDR_FLAG, 32'h01);
    chk({31'h0, irq_n}, 32'h1);
    set_temp(9'h046, SETTLE);
    chk_reg(ADDR_SENSE, 32'h80);
    axi_write(ADDR_MASK, 32'h0, 2'h0);
    repeat (3) @(posedge clock);
    #1;
    chk({31'h0, irq_n}, 32'h0);
    axi_write(ADDR_FLAG, 32'h01, 2'h0);
    $display("test_debounce_mask done");
  endtask

  task automatic test_modes();
    axi_write(ADDR_CTRL, 32'h0, 2'h0);
    set_temp(9'h064, 3 * SETTLE);
    chk({31'h0, mon_on}, 32'h0);
    chk_reg(ADDR_SENSE, 32'h0);
    axi_write(ADDR_CTRL, 32'h1, 2'h0);
    repeat (INTV) @(posedge clock);
    count_on(3 * INTV, 3 * WIN);
    @(posedge clock);
    standby <= 1'b1;
    axi_write(ADDR_CTRL, 32'h3, 2'h0);
    repeat (INTV) @(posedge clock);
    count_on(3 * INTV, 3 * WIN);
    axi_write(ADDR_CTRL, 32'h2, 2'h0);
    repeat (5) @(posedge clock);
    count_on(2 * INTV, 0);
    @(posedge clock);
    standby <= 1'b0;
    axi_write(ADDR_CTRL, 32'h3, 2'h0);
    repeat (5) @(posedge clock);
    count_on(2 * INTV, 2 * INTV);
    @(posedge clock);
    standby <= 1'b1;
    repeat (5) @(posedge clock);
    count_on(2 * INTV, 2 * WIN);
    $display("test_modes done");
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    test_reset();
    test_levels();
    test_hysteresis();
    test_debounce_mask();
    test_modes();
    give_verdict();
  end
endmodule
